// ---- core/tlam_top.sv ----
// thermistor limits, alert enables, alert flags and alert pin
`timescale 1ns/1ps
// How it works
// - signed upper thermistor threshold at 0x0b; reading above it is out of range
// - signed lower thermistor threshold at 0x0c; reading below it is out of range
// - thermistor high alert gated by enable, latched, cleared by host at flag
// - thermistor low alert gated by enable, latched, cleared by host at flag
// - sixteen bit enable register at 0x0d, resets to zero, gates alert line
// - telemetry ready enable raises alert when readings become valid
// - telemetry ready held low for about 12 ms after telemetry starts
// - charger stays disabled until warm-up ends, whatever the enable says
// - resistance done enable raises alert on measurement completion
// - battery voltage low enable raises alert below its limit
// - battery voltage high enable raises alert above its limit
// - input voltage low enable raises alert below its limit
// - input voltage high enable raises alert above its limit
// - output voltage low enable raises alert below its limit
// - output voltage high enable raises alert above its limit
// - bits 5 to 0 gate current, die, resistance and thermistor alerts
module tlam_top
  import tlam_pkg::*;
#(
  parameter int WARMUP_LEN = WARMUP_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic telem_on_i,
  input wire logic ntc_sample_i,
  input wire logic [15:0] ntc_reading_i,
  input wire logic [15:0] ext_event_i,
  output logic telem_valid_o,
  output logic charger_enable_o,
  input wire logic smbalert_i,
  output logic smbalert_o,
  output logic smbalert_oe_o
);
  import tlam_pkg::*;

  tlam_flag_if fl ();

  tlam_flag_bank u_bank (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .fl(fl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] ntc_upper_threshold_q;
  logic [15:0] ntc_upper_threshold_d;
  logic [15:0] ntc_lower_threshold_q;
  logic [15:0] ntc_lower_threshold_d;
  logic [15:0] limit_alert_enables_q;
  logic [15:0] limit_alert_enables_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    ntc_upper_threshold_d = ntc_upper_threshold_q;
    ntc_lower_threshold_d = ntc_lower_threshold_q;
    limit_alert_enables_d = limit_alert_enables_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_NTC_UPPER: ntc_upper_threshold_d = reg_wdata_i;
        ADDR_NTC_LOWER: ntc_lower_threshold_d = reg_wdata_i;
        ADDR_ENABLES: limit_alert_enables_d = reg_wdata_i & ENABLE_MASK;
        default: ;
      endcase
    end
    rvalid_d = reg_rd_i;
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_NTC_UPPER: rdata_d = ntc_upper_threshold_q;
        ADDR_NTC_LOWER: rdata_d = ntc_lower_threshold_q;
        ADDR_ENABLES: rdata_d = limit_alert_enables_q;
        ADDR_FLAGS: rdata_d = fl.flags;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ntc_upper_threshold_q <= RST_NTC_UPPER;
      ntc_lower_threshold_q <= RST_NTC_LOWER;
      limit_alert_enables_q <= RST_ENABLES;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      ntc_upper_threshold_q <= ntc_upper_threshold_d;
      ntc_lower_threshold_q <= ntc_lower_threshold_d;
      limit_alert_enables_q <= limit_alert_enables_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // flags are cleared by writing zero to their bit, ones leave them alone
  assign fl.wr = reg_wr_i && (reg_addr_i == ADDR_FLAGS);
  assign fl.wdata = reg_wdata_i;

  ////////////////////////////////////////////////////////////////////////////
  // telemetry warm-up

  logic [WARMUP_W-1:0] warm_cnt_q;
  logic [WARMUP_W-1:0] warm_cnt_d;
  logic telem_valid_q;
  logic telem_valid_d;
  logic telem_rise;

  always_comb begin
    warm_cnt_d = warm_cnt_q;
    telem_valid_d = telem_valid_q;
    if (!telem_on_i) begin
      // a restart of telemetry repeats the full warm-up
      warm_cnt_d = '0;
      telem_valid_d = 1'b0;
    end else if (warm_cnt_q != WARMUP_W'(WARMUP_LEN - 1)) begin
      warm_cnt_d = warm_cnt_q + 1'b1;
    end else begin
      telem_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      warm_cnt_q <= '0;
      telem_valid_q <= 1'b0;
    end else begin
      warm_cnt_q <= warm_cnt_d;
      telem_valid_q <= telem_valid_d;
    end
  end

  assign telem_rise = telem_valid_d && !telem_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // alert sources

  logic ntc_hi;
  logic ntc_lo;
  logic [15:0] raw_event;

  // signed compare: the thermistor reading may go negative near zero
  assign ntc_hi = ntc_sample_i &&
    ($signed(ntc_reading_i) > $signed(ntc_upper_threshold_q));
  assign ntc_lo = ntc_sample_i &&
    ($signed(ntc_reading_i) < $signed(ntc_lower_threshold_q));

  // outside comparators report crossings; bits 15, 13:12 and 1:0 are never taken from them
  always_comb begin
    raw_event = 16'h0000;
    raw_event[BIT_TELEM_VALID] = telem_rise;
    raw_event[BIT_BSR_DONE] = ext_event_i[BIT_BSR_DONE];
    raw_event[BIT_VBAT_LO] = ext_event_i[BIT_VBAT_LO];
    raw_event[BIT_VBAT_HI] = ext_event_i[BIT_VBAT_HI];
    raw_event[BIT_VIN_LO] = ext_event_i[BIT_VIN_LO];
    raw_event[BIT_VIN_HI] = ext_event_i[BIT_VIN_HI];
    raw_event[BIT_VOUT_LO] = ext_event_i[BIT_VOUT_LO];
    raw_event[BIT_VOUT_HI] = ext_event_i[BIT_VOUT_HI];
    raw_event[BIT_IIN_HI] = ext_event_i[BIT_IIN_HI];
    raw_event[BIT_IBAT_LO] = ext_event_i[BIT_IBAT_LO];
    raw_event[BIT_DIE_HI] = ext_event_i[BIT_DIE_HI];
    raw_event[BIT_BSR_HI] = ext_event_i[BIT_BSR_HI];
    raw_event[BIT_NTC_HI] = ntc_hi;
    raw_event[BIT_NTC_LO] = ntc_lo;
  end

  assign fl.set = raw_event & limit_alert_enables_q;

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic alert_oe_q;
  logic alert_oe_d;
  logic charger_en_q;
  logic charger_en_d;

  always_comb begin
    // flag of a later disabled source no longer holds the line
    alert_oe_d = |(fl.flags & limit_alert_enables_q);
    charger_en_d = telem_valid_d;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      alert_oe_q <= 1'b0;
      charger_en_q <= 1'b0;
    end else begin
      alert_oe_q <= alert_oe_d;
      charger_en_q <= charger_en_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign telem_valid_o = telem_valid_q;
  assign charger_enable_o = charger_en_q;
  assign smbalert_oe_o = alert_oe_q;
  // open drain: only ever pulls low
  assign smbalert_o = 1'b0;
endmodule

// ---- core/tlam_pkg.sv ----
// constants for the telemetry limit alert monitor
package tlam_pkg;
  localparam logic [7:0] ADDR_NTC_UPPER = 8'h0b;
  localparam logic [7:0] ADDR_NTC_LOWER = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES = 8'h0d;
  localparam logic [7:0] ADDR_FLAGS = 8'h36;
  localparam logic [15:0] RST_NTC_UPPER = 16'h0000;
  localparam logic [15:0] RST_NTC_LOWER = 16'h0000;
  localparam logic [15:0] RST_ENABLES = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam int BIT_TELEM_VALID = 15;
  localparam int BIT_BSR_DONE = 14;
  localparam int BIT_VBAT_LO = 11;
  localparam int BIT_VBAT_HI = 10;
  localparam int BIT_VIN_LO = 9;
  localparam int BIT_VIN_HI = 8;
  localparam int BIT_VOUT_LO = 7;
  localparam int BIT_VOUT_HI = 6;
  localparam int BIT_IIN_HI = 5;
  localparam int BIT_IBAT_LO = 4;
  localparam int BIT_DIE_HI = 3;
  localparam int BIT_BSR_HI = 2;
  localparam int BIT_NTC_HI = 1;
  localparam int BIT_NTC_LO = 0;
  // bits 13:12 are reserved and read as zero
  localparam logic [15:0] ENABLE_MASK = 16'hcfff;
  // bits fed by outside comparators and the resistance measurement
  localparam logic [15:0] EXT_MASK = 16'h4ffc;
  localparam int CLK_KHZ = 20000;
  localparam int WARMUP_MS = 12;
  localparam int WARMUP_CYCLES = WARMUP_MS * CLK_KHZ;
  localparam int WARMUP_W = 18;
endpackage

// ---- core/tlam_flag_if.sv ----
// carrier between the controller and its alert flag bank
`timescale 1ns/1ps
interface tlam_flag_if;
  logic [15:0] set;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] flags;
  modport bank (input set, input wr, input wdata, output flags);
  modport ctrl (output set, output wr, output wdata, input flags);
endinterface

// ---- core/tlam_flag_bank.sv ----
// sticky alert flags, written with zero to clear
`timescale 1ns/1ps
module tlam_flag_bank
  import tlam_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  tlam_flag_if.bank fl
);
  logic [15:0] flags_q;
  logic [15:0] flags_d;

  always_comb begin
    flags_d = flags_q;
    if (fl.wr) begin
      flags_d = flags_q & fl.wdata;
    end
    // set after clear so an event in the clearing cycle survives
    flags_d = (flags_d | fl.set) & ENABLE_MASK;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;
endmodule

// ---- tb/tlam_asserts.sv ----
// port assertions for the alert monitor
`timescale 1ns/1ps
module tlam_asserts
  import tlam_pkg::*;
#(
  parameter int WARMUP_LEN = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic telem_on_i,
  input wire logic ntc_sample_i,
  input wire logic [15:0] ext_event_i,
  input wire logic telem_valid_o,
  input wire logic charger_enable_o,
  input wire logic smbalert_o,
  input wire logic smbalert_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // no event may set a flag during the clear
  sequence s_quiet;
    !ntc_sample_i && ext_event_i == 16'h0000 && $stable(telem_valid_o);
  endsequence
  sequence s_clr;
    (reg_wr_i && reg_addr_i == ADDR_FLAGS && reg_wdata_i == 16'h0000) and s_quiet;
  endsequence
  a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_only_read: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("stray read valid");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  a_reserved_zero: assert property (reg_rvalid_o && $past(reg_addr_i) == ADDR_ENABLES
    |-> reg_rdata_o[13:12] == 2'b00) else $error("reserved enable bits set");
  a_charger_with_valid: assert property (charger_enable_o == telem_valid_o)
    else $error("charger enable apart from ready");
  a_restart_clears: assert property (!telem_on_i ##1 !telem_on_i |=> !telem_valid_o)
    else $error("ready kept over restart");
  a_warmup_low: assert property ($rose(telem_on_i) |-> !telem_valid_o [*8])
    else $error("ready too early");
  a_pin_data_low: assert property (smbalert_o == 1'b0)
    else $error("alert data not low");
  a_clear_frees: assert property (s_clr ##1 s_quiet |=> !smbalert_oe_o)
    else $error("alert held after clear");
  a_enable_off_frees: assert property (reg_wr_i && reg_addr_i == ADDR_ENABLES
    && reg_wdata_i == 16'h0000 |-> ##2 !smbalert_oe_o) else $error("alert held, no enable");
endmodule
bind tlam_top tlam_asserts #(.WARMUP_LEN(WARMUP_LEN)) u_asserts (
  .clock_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .reg_rvalid_o, .telem_on_i, .ntc_sample_i, .ext_event_i,
  .telem_valid_o, .charger_enable_o, .smbalert_o, .smbalert_oe_o);

// ---- tb/tlam_host.sv ----
// host side of the alert wire
`timescale 1ns/1ps
module tlam_host (
  input wire logic alert_oe_i,
  output logic alert_n_o
);
  // open drain with pull-up: high unless the device pulls
  assign alert_n_o = alert_oe_i ? 1'b0 : 1'b1;
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the alert monitor
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
  import tlam_pkg::*;
  logic clock_i = 0, nrst_i = 0, wr = 0, rd = 0, ton = 0, smp = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000, rdg = 16'h0000, ev = 16'h0000, rdata;
  logic rvalid, valid, chg, pin, oe, line_n;
  int n_mismatch = 0, comparisons = 0, i;
  logic [39:0] rows [4] = '{{8'h0b, 16'h8001, 16'h8001}, {8'h0c, 16'h7fff, 16'h7fff},
    {8'h0d, 16'hffff, 16'hcfff}, {8'h20, 16'h1234, 16'h0000}};
  logic [31:0] ntc [4] = '{{16'h8000, 16'h0001}, {16'h0011, 16'h0002},
    {16'h0010, 16'h0000}, {16'hfff0, 16'h0000}};
  always #25 clock_i = ~clock_i;
  tlam_top #(.WARMUP_LEN(8)) DUT (.clock_i, .nrst_i, .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .telem_on_i(ton), .ntc_sample_i(smp), .ntc_reading_i(rdg), .ext_event_i(ev),
    .telem_valid_o(valid), .charger_enable_o(chg), .smbalert_i(line_n),
    .smbalert_o(pin), .smbalert_oe_o(oe));
  tlam_host host (.alert_oe_i(oe), .alert_n_o(line_n));
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock_i) {addr, wd, wr} = {a, d, 1'b1};
    @(negedge clock_i) wr = 0;
  endtask
  task rreg(input logic [7:0] a, input logic [15:0] e);
    @(negedge clock_i) {addr, rd} = {a, 1'b1};
    @(negedge clock_i) rd = 0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask
  task pulse(input logic s, input logic [15:0] r, input logic [15:0] e);
    @(negedge clock_i) {smp, rdg, ev} = {s, r, e};
    @(negedge clock_i) {smp, ev} = 17'h0_0000;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (10) @(negedge clock_i);
    nrst_i = 1;
    rreg(ADDR_NTC_UPPER, RST_NTC_UPPER);
    rreg(ADDR_NTC_LOWER, RST_NTC_LOWER);
    rreg(ADDR_ENABLES, RST_ENABLES);
    for (i = 0; i < 4; i++) begin
      wreg(rows[i][39:32], rows[i][31:16]);
      rreg(rows[i][39:32], rows[i][15:0]);
    end
    wreg(ADDR_ENABLES, 16'h8003);
    wreg(ADDR_NTC_UPPER, 16'h0010);
    wreg(ADDR_NTC_LOWER, 16'hfff0);
    ton = 1;
    repeat (7) @(negedge clock_i);
    `CHK("valid early", 1'b0, valid)
    `CHK("charger early", 1'b0, chg)
    for (i = 0; i < 4 && valid !== 1'b1; i++) @(negedge clock_i);
    `CHK("charger", 1'b1, chg)
    repeat (2) @(negedge clock_i);
    `CHK("alert line", 1'b0, line_n)
    rreg(ADDR_FLAGS, 16'h8000);
    wreg(ADDR_FLAGS, 16'h0000);
    repeat (2) @(negedge clock_i);
    `CHK("oe freed", 1'b0, oe)
    for (i = 0; i < 4; i++) begin
      pulse(1'b1, ntc[i][31:16], 16'h0000);
      rreg(ADDR_FLAGS, ntc[i][15:0]);
      wreg(ADDR_FLAGS, 16'h0000);
    end
    wreg(ADDR_ENABLES, 16'hffff);
    // every event line, ignored ones too
    for (i = 0; i < 16; i++) begin
      pulse(1'b0, 16'h0000, 16'h0001 << i);
      rreg(ADDR_FLAGS, EXT_MASK & (16'h0001 << i));
      wreg(ADDR_FLAGS, 16'h0000);
    end
    wreg(ADDR_ENABLES, 16'h0000);
    pulse(1'b1, 16'h8000, 16'hffff);
    rreg(ADDR_FLAGS, 16'h0000);
    wreg(ADDR_ENABLES, 16'h0004);
    pulse(1'b0, 16'h0000, 16'h0004);
    repeat (2) @(negedge clock_i);
    `CHK("oe set", 1'b1, oe)
    wreg(ADDR_FLAGS, 16'hffff);
    repeat (3) @(negedge clock_i);
    `CHK("oe kept", 1'b1, oe)
    wreg(ADDR_ENABLES, 16'h0000);
    repeat (2) @(negedge clock_i);
    `CHK("oe disabled", 1'b0, oe)
    rreg(ADDR_FLAGS, 16'h0004);
    ton = 0;
    repeat (2) @(negedge clock_i);
    `CHK("valid restart", 1'b0, valid)
    `CHK("charger restart", 1'b0, chg)
    `CHK("alert data", 1'b0, pin)
    wreg(ADDR_ENABLES, 16'h0004);
    nrst_i = 0;
    repeat (2) @(negedge clock_i);
    `CHK("oe in reset", 1'b0, oe)
    nrst_i = 1;
    rreg(ADDR_ENABLES, RST_ENABLES);
    rreg(ADDR_FLAGS, RST_FLAGS);
    end_sim;
  end
endmodule
